/* File: hdl/jsw_mode_switch.sv */
// Debug port mode switch with pin takeover, commit protection and recovery erase.
//
// Operation
// RQ1 - Any reset restores debug pin configuration defaults.
// RQ2 - Cleared alternate select hands pins to GPIO.
// RQ3 - Protected writes need open lock and commit.
// RQ4 - Ten alternating switches under reset erase flash.
// RQ5 - Probe recovery: hold reset, ten switches, power-cycle.
// RQ6 - Erase completes before nonvolatile defaults restore.
// RQ7 - Probe may omit trailing highs during recovery.
// RQ8 - Preamble counts only when starting in Test-Logic-Reset.
// RQ9 - Completed TAP walk enables SWD, disables JTAG.
// RQ10 - Pattern 0xE79E, LSB first, selects SWD.
// RQ11 - Probe sends fifty highs before each pattern.
// RQ12 - Fifty highs after switch give SWD line reset.
// RQ13 - Pattern 0xE73C, LSB first, selects JTAG.
// RQ14 - Five highs after JTAG switch reach Test-Logic-Reset.
// RQ15 - No debug until alternate select restored.
// RQ16 - TAP chains have no bus-visible registers.
// RQ17 - Five high mode edges force Test-Logic-Reset.
// RQ18 - Last sixteen samples compared against both patterns.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`default_nettype none

module jsw_mode_switch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [jsw_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [jsw_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk_pin,
  input wire logic mode_data_pin,
  input wire logic ext_reset_n_pin,
  input wire logic flash_erase_done,
  input wire logic nv_restore_done,
  output logic [jsw_pkg::DBG_PINS-1:0] pin_digital_enable,
  output logic [jsw_pkg::DBG_PINS-1:0] pin_pullup_select,
  output logic [jsw_pkg::DBG_PINS-1:0] pin_alt_function_select,
  output logic debug_pins_connected,
  output logic swd_enable,
  output logic tap_logic_reset,
  output logic swd_line_reset,
  output logic flash_erase_req,
  output logic nv_restore_req
);

  localparam int unsigned NP = jsw_pkg::DBG_PINS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Every flip-flop of the block outside the pin synchroniser lives in this one record.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [jsw_pkg::AXI_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [NP-1:0] afsel;
    logic [NP-1:0] pur;
    logic [NP-1:0] den;
    logic unlocked;
    logic [NP-1:0] commit;
    logic connected;
    logic [15:0] hist;
    logic swd_mode;
    logic [5:0] highs;
    logic tap_tlr;
    logic line_reset;
    logic [3:0] pre_step;
    logic [3:0] rec_count;
    logic rec_expect_swd;
    jsw_pkg::jsw_phase_type phase;
    logic erase_req;
    logic restore_req;
  } jsw_ctrl_state_type;

  jsw_ctrl_state_type st_ff;
  jsw_ctrl_state_type nxt_st;

  // Synchronised pins: mode/data line and the external reset, active low.
  logic [1:0] pins_sync;
  logic tck_rise;
  logic tms_s;
  logic ext_rst_n_s;

  // Combinational helpers of the next-state process.
  logic [15:0] hist_n;
  logic [5:0] highs_n;
  logic to_swd;
  logic to_jtag;
  logic pre_done;
  logic [NP-1:0] allow;
  jsw_pkg::jsw_reg_sel_type sel_w;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Map a byte address to a register; shared by the read and write paths.
  function automatic jsw_pkg::jsw_reg_sel_type reg_sel(
    input logic [jsw_pkg::AXI_ADDR_W-1:0] addr
  );
    jsw_pkg::jsw_reg_sel_type s;
    s = jsw_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr)
        jsw_pkg::OFS_ALT_FUNC: s = jsw_pkg::SEL_ALT;
        jsw_pkg::OFS_PULLUP: s = jsw_pkg::SEL_PULL;
        jsw_pkg::OFS_DIG_EN: s = jsw_pkg::SEL_DEN;
        jsw_pkg::OFS_LOCK: s = jsw_pkg::SEL_LOCK;
        jsw_pkg::OFS_COMMIT: s = jsw_pkg::SEL_COMMIT;
        jsw_pkg::OFS_STATUS: s = jsw_pkg::SEL_STATUS;
        default: s = jsw_pkg::SEL_NONE;
      endcase
    end
    return s;
  endfunction : reg_sel

  // Only bits opened by the commit mask take the written value.
  function automatic logic [NP-1:0] protect(
    input logic [NP-1:0] old_v,
    input logic [NP-1:0] new_v,
    input logic [NP-1:0] open_v
  );
    return (old_v & ~open_v) | (new_v & open_v);
  endfunction : protect

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  jsw_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_pin(link_clk_pin),
    .data_pins({ext_reset_n_pin, mode_data_pin}),
    .data_sync(pins_sync),
    .clk_rise(tck_rise)
  );

  assign tms_s = pins_sync[0];
  assign ext_rst_n_s = pins_sync[1];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus slave, pin configuration, link decoding and recovery in one pass.
  always_comb begin
    nxt_st = st_ff;
    hist_n = {tms_s, st_ff.hist[15:1]};
    highs_n = '0;
    to_swd = 1'b0;
    to_jtag = 1'b0;
    pre_done = 1'b0;
    allow = st_ff.unlocked ? st_ff.commit : '0;
    sel_w = reg_sel(st_ff.awaddr);

    // Commit a write once address and data are both held.
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (sel_w == jsw_pkg::SEL_NONE) ? jsw_pkg::RESP_DECERR : jsw_pkg::RESP_OKAY;
      if (st_ff.wstrb[0]) begin
        unique case (sel_w)
          jsw_pkg::SEL_ALT: nxt_st.afsel = protect(st_ff.afsel, st_ff.wdata[NP-1:0], allow); // [RQ3]
          jsw_pkg::SEL_PULL: nxt_st.pur = protect(st_ff.pur, st_ff.wdata[NP-1:0], allow); // [RQ3]
          jsw_pkg::SEL_DEN: nxt_st.den = protect(st_ff.den, st_ff.wdata[NP-1:0], allow); // [RQ3]
          // Any value but the key closes the lock again.
          jsw_pkg::SEL_LOCK: nxt_st.unlocked = (st_ff.wdata == jsw_pkg::UNLOCK_KEY);
          jsw_pkg::SEL_COMMIT: begin
            if (st_ff.unlocked) begin
              nxt_st.commit = st_ff.wdata[NP-1:0]; // [RQ3]
            end
          end
          jsw_pkg::SEL_STATUS, jsw_pkg::SEL_NONE: begin
            // Read-only or unmapped: nothing is stored.
          end
        endcase
      end
    end

    // Take address and data in either order.
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = jsw_pkg::RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        jsw_pkg::SEL_ALT: nxt_st.rdata = {28'h0000000, st_ff.afsel};
        jsw_pkg::SEL_PULL: nxt_st.rdata = {28'h0000000, st_ff.pur};
        jsw_pkg::SEL_DEN: nxt_st.rdata = {28'h0000000, st_ff.den};
        jsw_pkg::SEL_LOCK: nxt_st.rdata = {31'h00000000, !st_ff.unlocked};
        jsw_pkg::SEL_COMMIT: nxt_st.rdata = {28'h0000000, st_ff.commit};
        jsw_pkg::SEL_STATUS: begin
          nxt_st.rdata = {20'h00000, st_ff.rec_count, 2'h0, st_ff.restore_req,
                          st_ff.erase_req, st_ff.line_reset, st_ff.tap_tlr,
                          st_ff.connected, st_ff.swd_mode};
        end
        jsw_pkg::SEL_NONE: begin
          // The scan chains have no address; everything else decodes here.
          nxt_st.rdata = 32'h00000000; // [RQ16]
          nxt_st.rresp = jsw_pkg::RESP_DECERR;
        end
      endcase
    end

    // A held external reset forces the debug configuration over software.
    if (!ext_rst_n_s) begin
      nxt_st.afsel = jsw_pkg::PIN_CFG_RESET; // [RQ1]
      nxt_st.pur = jsw_pkg::PIN_CFG_RESET; // [RQ1]
      nxt_st.den = jsw_pkg::PIN_CFG_RESET; // [RQ1]
      nxt_st.unlocked = 1'b0;
      nxt_st.commit = '0;
    end
    // Debug needs all four pins on their alternate function.
    nxt_st.connected = &nxt_st.afsel; // [RQ2] [RQ15]

    // Link decoding, only while the pins belong to the debug port.
    if (tck_rise && st_ff.connected) begin // [RQ15]
      nxt_st.hist = hist_n; // [RQ18]
      highs_n = !tms_s ? 6'h00 : (st_ff.highs == jsw_pkg::HIGHS_MAX) ? st_ff.highs
                : st_ff.highs + 6'h01;
      to_swd = (hist_n == jsw_pkg::SWITCH_TO_SWD); // [RQ10] [RQ18]
      to_jtag = (hist_n == jsw_pkg::SWITCH_TO_JTAG); // [RQ13] [RQ18]
      // The TAP walk only starts from Test-Logic-Reset.
      if (tms_s != jsw_pkg::PREAMBLE_TMS[st_ff.pre_step]) begin
        nxt_st.pre_step = 4'h0;
      end else if (st_ff.pre_step == 4'h0 && !st_ff.tap_tlr) begin
        nxt_st.pre_step = 4'h0; // [RQ8]
      end else if (st_ff.pre_step == jsw_pkg::PREAMBLE_LAST) begin
        nxt_st.pre_step = 4'h0;
        pre_done = 1'b1; // [RQ9]
      end else begin
        nxt_st.pre_step = st_ff.pre_step + 4'h1; // [RQ9]
      end
      // A switch restarts the high count so the tail is counted afresh.
      if (to_swd || pre_done) begin
        nxt_st.swd_mode = 1'b1; // [RQ9] [RQ10]
        highs_n = '0;
      end else if (to_jtag) begin
        nxt_st.swd_mode = 1'b0; // [RQ13]
        highs_n = '0;
      end
      nxt_st.highs = highs_n;
      nxt_st.tap_tlr = tms_s && (st_ff.tap_tlr || highs_n >= jsw_pkg::TAP_RESET_HIGHS); // [RQ17]
      nxt_st.line_reset = nxt_st.swd_mode && highs_n >= jsw_pkg::SWD_LINE_RESET_HIGHS; // [RQ12]
    end

    // Recovery: count switches in turn while the reset pin is held low.
    if (!ext_rst_n_s) begin
      if ((to_swd && st_ff.rec_expect_swd) || (to_jtag && !st_ff.rec_expect_swd)) begin
        if (st_ff.rec_count != jsw_pkg::RECOVERY_SWITCHES) begin
          nxt_st.rec_count = st_ff.rec_count + 4'h1; // [RQ4]
          nxt_st.rec_expect_swd = !st_ff.rec_expect_swd;
          if (nxt_st.rec_count == jsw_pkg::RECOVERY_SWITCHES &&
              st_ff.phase == jsw_pkg::PH_IDLE) begin
            nxt_st.phase = jsw_pkg::PH_ERASE;
            nxt_st.erase_req = 1'b1; // [RQ4]
          end
        end
      end
    end else begin
      nxt_st.rec_count = 4'h0;
      nxt_st.rec_expect_swd = 1'b1;
    end

    // Erase first, and only then restore the nonvolatile defaults.
    unique case (st_ff.phase)
      jsw_pkg::PH_IDLE: begin
      end
      jsw_pkg::PH_ERASE: begin
        if (flash_erase_done) begin
          nxt_st.erase_req = 1'b0;
          nxt_st.restore_req = 1'b1; // [RQ6]
          nxt_st.phase = jsw_pkg::PH_RESTORE;
        end
      end
      jsw_pkg::PH_RESTORE: begin
        if (nv_restore_done) begin
          nxt_st.restore_req = 1'b0;
          nxt_st.phase = jsw_pkg::PH_IDLE;
        end
      end
      default: begin
        nxt_st.phase = jsw_pkg::PH_IDLE;
      end
    endcase

    // Ready only while nothing is held or waiting for its answer.
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset puts the pins on the debug port and the TAP in Test-Logic-Reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.afsel <= jsw_pkg::PIN_CFG_RESET; // [RQ1]
      st_ff.pur <= jsw_pkg::PIN_CFG_RESET; // [RQ1]
      st_ff.den <= jsw_pkg::PIN_CFG_RESET; // [RQ1]
      st_ff.connected <= 1'b1;
      st_ff.tap_tlr <= 1'b1;
      st_ff.rec_expect_swd <= 1'b1;
      st_ff.phase <= jsw_pkg::PH_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign pin_digital_enable = st_ff.den;
  assign pin_pullup_select = st_ff.pur;
  assign pin_alt_function_select = st_ff.afsel;
  assign debug_pins_connected = st_ff.connected;
  assign swd_enable = st_ff.swd_mode;
  assign tap_logic_reset = st_ff.tap_tlr;
  assign swd_line_reset = st_ff.line_reset;
  assign flash_erase_req = st_ff.erase_req;
  assign nv_restore_req = st_ff.restore_req;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A link edge that the decoder accepts.
  sequence s_link_edge;
    tck_rise && st_ff.connected;
  endsequence

  a_reset_pin_defaults: assert property (!ext_rst_n_s |=> st_ff.afsel == 4'hF && st_ff.den == 4'hF && st_ff.pur == 4'hF) else $error("pins not on debug port under reset"); // [RQ1]
  a_gpio_no_debug: assert property (!st_ff.connected |=> $stable(st_ff.swd_mode) && $stable(st_ff.hist)) else $error("debug decoded while pins are GPIO"); // [RQ2] [RQ15]
  a_locked_write_drop: assert property (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid && !st_ff.unlocked && ext_rst_n_s |=> $stable(st_ff.afsel) && $stable(st_ff.pur) && $stable(st_ff.den)) else $error("protected bit written while locked"); // [RQ3]
  a_erase_after_ten: assert property ($rose(st_ff.erase_req) |-> $past(st_ff.rec_count) == 4'h9 && st_ff.rec_count == 4'hA && !$past(ext_rst_n_s)) else $error("erase without ten switches"); // [RQ4]
  a_erase_before_restore: assert property ($rose(st_ff.restore_req) |-> $past(flash_erase_done) && $fell(st_ff.erase_req)) else $error("restore before erase finished"); // [RQ6]
  a_swd_pattern: assert property (s_link_edge ##0 ({tms_s, st_ff.hist[15:1]} == 16'hE79E) |=> st_ff.swd_mode && st_ff.highs == 6'h00) else $error("SWD pattern missed"); // [RQ10] [RQ18]
  a_jtag_pattern: assert property (s_link_edge ##0 ({tms_s, st_ff.hist[15:1]} == 16'hE73C) |=> !st_ff.swd_mode) else $error("JTAG pattern missed"); // [RQ13] [RQ18]
  a_tap_five_highs: assert property ((s_link_edge ##0 tms_s && st_ff.highs == 6'h04 && {tms_s, st_ff.hist[15:1]} != 16'hE73C && {tms_s, st_ff.hist[15:1]} != 16'hE79E) |=> st_ff.tap_tlr) else $error("TAP not reset after five highs"); // [RQ14] [RQ17]
  a_swd_line_reset: assert property ((s_link_edge ##0 tms_s && st_ff.swd_mode && st_ff.highs == 6'h31 && {tms_s, st_ff.hist[15:1]} != 16'hE73C) |=> st_ff.line_reset) else $error("no line reset after fifty highs"); // [RQ12]
  a_preamble_start: assert property (s_link_edge ##0 st_ff.pre_step == 4'h0 && !st_ff.tap_tlr |=> st_ff.pre_step == 4'h0) else $error("TAP walk began outside reset"); // [RQ8]
  a_preamble_done: assert property (s_link_edge ##0 st_ff.pre_step == 4'hF && tms_s |=> st_ff.swd_mode) else $error("TAP walk did not enable SWD"); // [RQ9]

endmodule : jsw_mode_switch

`default_nettype wire

/* File: hdl/jsw_pkg.sv */
// Shared constants and types for the debug port mode switch block.
`default_nettype none

package jsw_pkg;

  // ----------------------------------------------------------------
  // Pin configuration
  // ----------------------------------------------------------------
  // Number of shared debug port pins.
  localparam int unsigned DBG_PINS = 4;
  // Value of the pin configuration fields after any reset.
  localparam logic [3:0] PIN_CFG_RESET = 4'hF;
  // Lock key that opens the port; the value is arbitrary.
  localparam logic [31:0] UNLOCK_KEY = 32'h600D_C0DE;

  // ----------------------------------------------------------------
  // Switch patterns, sent least significant bit first
  // ----------------------------------------------------------------
  localparam logic [15:0] SWITCH_TO_SWD = 16'hE79E;
  localparam logic [15:0] SWITCH_TO_JTAG = 16'hE73C;
  // Mode line values of the TAP walk, bit 0 first; it is the same bit string.
  localparam logic [15:0] PREAMBLE_TMS = 16'hE79E;
  // Index of the last step of the TAP walk.
  localparam logic [3:0] PREAMBLE_LAST = 4'hF;

  // ----------------------------------------------------------------
  // Counts of link clock cycles and of recovery switches
  // ----------------------------------------------------------------
  localparam logic [5:0] TAP_RESET_HIGHS = 6'h05;
  localparam logic [5:0] SWD_LINE_RESET_HIGHS = 6'h32;
  localparam logic [5:0] HIGHS_MAX = 6'h3F;
  localparam logic [3:0] RECOVERY_SWITCHES = 4'hA;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_ALT_FUNC = 8'h00;
  localparam logic [7:0] OFS_PULLUP = 8'h04;
  localparam logic [7:0] OFS_DIG_EN = 8'h08;
  localparam logic [7:0] OFS_LOCK = 8'h0C;
  localparam logic [7:0] OFS_COMMIT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Register selected by an address.
  typedef enum logic [2:0] {
    SEL_ALT, SEL_PULL, SEL_DEN, SEL_LOCK, SEL_COMMIT, SEL_STATUS, SEL_NONE
  } jsw_reg_sel_type;

  // Progress of the locked-device recovery.
  typedef enum logic [1:0] {PH_IDLE, PH_ERASE, PH_RESTORE} jsw_phase_type;

endpackage : jsw_pkg

`default_nettype wire

/* File: hdl/jsw_pin_sync.sv */
// Two-stage synchroniser for the link pins with rising edge detect of the link clock.
`default_nettype none

module jsw_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_pin,
  input wire logic [WIDTH-1:0] data_pins,
  output logic [WIDTH-1:0] data_sync,
  output logic clk_rise
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // The first stage feeds only the second stage; edge logic reads stage two.
  typedef struct packed {
    logic [WIDTH:0] meta;
    logic [WIDTH:0] sync;
    logic clk_prev;
  } jsw_sync_state_type;

  jsw_sync_state_type st_ff;
  jsw_sync_state_type nxt_st;

  // Next state: shift both stages and remember the settled clock level.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = {clk_pin, data_pins};
    nxt_st.sync = st_ff.meta;
    nxt_st.clk_prev = st_ff.sync[WIDTH];
  end

  // Register the state; a synchronous reset loads constants only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Data is aligned with the clock so a sample at the edge sees settled data.
  assign data_sync = st_ff.sync[WIDTH-1:0];
  assign clk_rise = st_ff.sync[WIDTH] & ~st_ff.clk_prev;

endmodule : jsw_pin_sync

`default_nettype wire

/* File: tb/jsw_probe.sv */
// Behavioural debug probe that drives the link clock and the mode line.
`default_nettype none
module jsw_probe (
  output logic link_clk_pin,
  output logic mode_data_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // The clock stands low between frames; the line idles high as its pull-up holds it.
  initial begin
    link_clk_pin = 1'b0;
    mode_data_pin = 1'b1;
  end
  // One bit per 200 ns cycle: data moves while the clock is low, so the rise sees it settled.
  task send_bit(input logic b);
    mode_data_pin = b;
    #100 link_clk_pin = 1'b1;
    #100 link_clk_pin = 1'b0;
  endtask : send_bit
  // A run of high cycles around a pattern.
  task send_highs(input int n);
    repeat (n) send_bit(1'b1);
  endtask : send_highs
  // A 16-bit switch pattern, least significant bit first.
  task send_pattern(input logic [15:0] p);
    for (int i = 0; i < 16; i++) begin
      send_bit(p[i]);
    end
    mode_data_pin = 1'b1;
  endtask : send_pattern
endmodule : jsw_probe
`default_nettype wire

/* File: tb/tb_jsw_mode_switch.sv */
// Self-checking bench for the debug port mode switch.
`default_nettype none
module tb_jsw_mode_switch;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, pin_digital_enable, pin_pullup_select, pin_alt_function_select;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic link_clk_pin, mode_data_pin, ext_reset_n_pin, flash_erase_done, nv_restore_done;
  logic debug_pins_connected, swd_enable, tap_logic_reset, swd_line_reset;
  logic flash_erase_req, nv_restore_req;
  int fails, check_count;
  // Register reads after reset: address, data, response.
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} jsw_row_type;
  localparam jsw_row_type ROWS [8] = '{'{8'h00, 32'hF, 2'h0}, '{8'h04, 32'hF, 2'h0},
    '{8'h08, 32'hF, 2'h0}, '{8'h0C, 32'h1, 2'h0}, '{8'h10, 32'h0, 2'h0},
    '{8'h14, 32'h6, 2'h0}, '{8'h18, 32'h0, 2'h3}, '{8'h02, 32'h0, 2'h3}};
  jsw_mode_switch u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_clk_pin, .mode_data_pin, .ext_reset_n_pin,
    .flash_erase_done, .nv_restore_done, .pin_digital_enable, .pin_pullup_select,
    .pin_alt_function_select, .debug_pins_connected, .swd_enable, .tap_logic_reset,
    .swd_line_reset, .flash_erase_req, .nv_restore_req);
  jsw_probe u_probe (.link_clk_pin, .mode_data_pin);
  // 40 MHz bus clock.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Case equality so that an unknown never counts as a match.
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Each channel is held until its own ready; the slave may take them in either order.
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      #1;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {ext_reset_n_pin, flash_erase_done, nv_restore_done} = 3'h4;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    foreach (ROWS[i]) begin
      axi_read(ROWS[i].a);
      cmp(rd, ROWS[i].d);
      cmp(32'(rsp), 32'(ROWS[i].r));
    end
    u_probe.send_highs(50);
    u_probe.send_pattern(16'hE79E);
    repeat (6) @(posedge aclk);
    cmp(32'(swd_enable), 32'h1);
    u_probe.send_highs(50);
    repeat (6) @(posedge aclk);
    cmp(32'(swd_line_reset), 32'h1);
    u_probe.send_pattern(16'hE73C);
    repeat (6) @(posedge aclk);
    cmp(32'({swd_enable, tap_logic_reset, swd_line_reset}), 32'h0);
    u_probe.send_highs(5);
    repeat (6) @(posedge aclk);
    cmp(32'(tap_logic_reset), 32'h1);
    // A locked port drops the write; opened and committed, it takes it.
    axi_write(8'h00, 32'h0);
    axi_read(8'h00);
    cmp(rd, 32'hF);
    axi_write(8'h0C, jsw_pkg::UNLOCK_KEY);
    axi_write(8'h10, 32'hF);
    axi_write(8'h00, 32'h0);
    cmp(32'({pin_alt_function_select, debug_pins_connected}), 32'h0);
    u_probe.send_highs(50);
    u_probe.send_pattern(16'hE79E);
    repeat (6) @(posedge aclk);
    cmp(32'(swd_enable), 32'h0);
    axi_write(8'h00, 32'hF);
    cmp(32'(debug_pins_connected), 32'h1);
    axi_write(8'h08, 32'h0);
    cmp(32'(pin_digital_enable), 32'h0);
    // Only the low byte lane carries the fields, so a write without it leaves them alone.
    s_axi_wstrb <= 4'h0;
    axi_write(8'h04, 32'h0);
    cmp(32'(pin_pullup_select), 32'hF);
    s_axi_wstrb <= 4'hF;
    axi_write(8'h04, 32'h0);
    cmp(32'(pin_pullup_select), 32'h0);
    axi_write(8'h18, 32'h0);
    cmp(32'(rsp), 32'h3);
    // Recovery: external reset held while ten alternating switches arrive.
    ext_reset_n_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    cmp(32'(pin_digital_enable), 32'hF);
    repeat (5) begin
      u_probe.send_highs(50);
      u_probe.send_pattern(16'hE79E);
      u_probe.send_highs(50);
      u_probe.send_pattern(16'hE73C);
    end
    repeat (6) @(posedge aclk);
    cmp(32'({flash_erase_req, nv_restore_req}), 32'h2);
    flash_erase_done <= 1'b1;
    repeat (2) @(posedge aclk);
    flash_erase_done <= 1'b0;
    cmp(32'({flash_erase_req, nv_restore_req}), 32'h1);
    nv_restore_done <= 1'b1;
    repeat (2) @(posedge aclk);
    nv_restore_done <= 1'b0;
    ext_reset_n_pin <= 1'b1;
    cmp(32'({flash_erase_req, nv_restore_req}), 32'h0);
    complete_run();
  end
  // Watchdog well beyond the roughly 175 us the sequence needs.
  initial begin
    #1ms;
    fails++;
    complete_run();
  end
endmodule : tb_jsw_mode_switch
`default_nettype wire
